// >>> hw/ifpa_pkg.sv
// shared constants for the instruction fetch pipeline
package ifpa_pkg;
    localparam int ADDR_W = 24;
    localparam int SHORT_W = 16;
    localparam int FETCH_SHORTS = 3;
    localparam int FETCH_W = 48;
    localparam int ALIGN_DEPTH = 5;
    localparam logic [23:0] RESET_ADDR = 24'h000000;
    localparam logic [23:0] NW_STEP = 24'h000001;
    localparam logic [23:0] SW_STEP = 24'h000003;
    localparam logic RESET_VARIABLE = 1'b0;
    localparam logic [2:0] RESET_COUNT = 3'h0;
    typedef enum logic [1:0] {
        IFPA_SRC_SEQ,
        IFPA_SRC_ADDR_STAGE,
        IFPA_SRC_EXEC_STAGE
    } ifpa_src_e;
endpackage : ifpa_pkg

// >>> hw/ifpa_align_fifo.sv
// five short-word alignment fifo feeding the decoder
`timescale 1ns/1ps
module ifpa_align_fifo #(
    parameter int DEPTH = 5,
    parameter int WORD_W = 16
) (
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire logic flush_i,
    input wire logic push_i,
    input wire logic [3*WORD_W-1:0] push_data_i,
    input wire logic [1:0] pop_len_i,
    output logic room_o,
    output logic [2:0] count_o,
    output logic [3*WORD_W-1:0] head_o
);
    logic [WORD_W-1:0] mem [DEPTH];
    logic [2:0] count;
    logic [2:0] kept;
    logic [2:0] pop_n;

    assign pop_n = ({1'b0, pop_len_i} > count) ? count : {1'b0, pop_len_i};
    assign kept = count - pop_n;
    // room only when three more short words fit
    assign room_o = (count <= 3'(DEPTH - 3));
    assign count_o = count;
    always_comb
    begin
        for (int i = 0; i < 3; i++)
        begin
            head_o[(3-i)*WORD_W-1 -: WORD_W] = (3'(i) < count) ? mem[i] : '0;
        end
    end

    // shift left past consumed words, then append fetch
    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            count <= ifpa_pkg::RESET_COUNT;
            for (int i = 0; i < DEPTH; i++)
            begin
                mem[i] <= '0;
            end
        end
        else if (flush_i)
        begin
            count <= ifpa_pkg::RESET_COUNT;
        end
        else
        begin
            for (int i = 0; i < DEPTH; i++)
            begin
                if (3'(i) < kept)
                begin
                    mem[i] <= mem[3'(i) + pop_n];
                end
                else if (push_i && 3'(i) < kept + 3'd3)
                begin
                    mem[i] <= push_data_i[(3-(i-int'(kept)))*WORD_W-1 -: WORD_W];
                end
            end
            count <= kept + (push_i ? 3'd3 : 3'd0);
        end
    end

    property p_no_overflow;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        count <= 3'(DEPTH);
    endproperty
    a_no_overflow: assert property (p_no_overflow) else $error("alignment fifo overflow");
endmodule : ifpa_align_fifo

// >>> hw/ifpa_pipeline.sv
// five-stage fetch pipeline with alignment fifo
// ----------------------------------------
// Functional notes
// - five interlocked stages, hazards stalled in hardware
// - space follows branch target, no mode bit
// - reset starts in fixed-width mode
// - keep fetch, decode and execute addresses
// - all addresses are 24 bits
// - fetch1 selects, drives, checks cache, increments one
// - short-word fetch address advances by three
// - fetch2 takes cache hit or bus data
// - decode controls, premodify, fills cache on miss in fixed-width mode only
// - address stage drives data, forwards jumps
// - execute forwards vector, fixed pc plus one
// - variable pc plus decoded length
// - fifo of five sixteen-bit short words
// - takes 48 bits, one instruction per cycle
// - stall fetch without room for 48
// - drop consumed words, align left
// - append three fetched words behind
// - one instruction per cycle sequential
// ----------------------------------------
`timescale 1ns/1ps
module ifpa_pipeline #(
    parameter int ADDR_W = 24,
    parameter int DEPTH = 5
) (
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire logic jump_valid_i,
    input wire logic [23:0] jump_target_i,
    input wire logic jump_variable_i,
    input wire logic vector_valid_i,
    input wire logic [23:0] vector_addr_i,
    input wire logic cache_hit_i,
    input wire logic [47:0] cache_data_i,
    input wire logic [47:0] mem_data_i,
    input wire logic mem_ready_i,
    input wire logic [1:0] instr_len_i,
    input wire logic hold_i,
    output logic [23:0] mem_addr_o,
    output logic mem_req_o,
    output logic cache_lookup_o,
    output logic cache_fill_o,
    output logic [23:0] cache_fill_addr_o,
    output logic [47:0] cache_fill_data_o,
    output logic [47:0] decode_instr_o,
    output logic decode_valid_o,
    output logic decode_variable_o,
    output logic [23:0] fetch_stage_address_o,
    output logic [23:0] decode_stage_address_o,
    output logic [23:0] pc_o,
    output logic exec_valid_o,
    output logic [1:0] exec_len_o,
    output logic variable_mode_o,
    output logic fetch_stall_o
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    logic variable_mode;
    logic [23:0] fetch_stage_address;
    logic [23:0] f2_addr;
    logic f2_valid;
    logic f2_hit;
    logic [23:0] decode_stage_address;
    logic dec_valid;
    logic [47:0] dec_word;
    logic dec_miss;
    logic [23:0] addr_stage;
    logic addr_valid;
    logic [1:0] addr_len;
    logic [23:0] pc;
    logic exec_valid;
    logic [1:0] exec_len;
    logic redirect;
    logic [23:0] redirect_addr;
    logic redirect_variable;
    logic fifo_room;
    logic [2:0] fifo_count;
    logic [47:0] fifo_head;
    logic fetch_go;
    logic advance;
    logic [1:0] dec_len;
    logic dec_ready;
    ifpa_pkg::ifpa_src_e src;

    function automatic logic [23:0] ifpa_step(input logic var_mode);
        return var_mode ? ifpa_pkg::SW_STEP : ifpa_pkg::NW_STEP;
    endfunction : ifpa_step

    // ----------------------------------------
    // fetch1 source select
    // ----------------------------------------
    // forwarded targets
    // execute vector outranks address stage, being older
    always_comb
    begin
        if (vector_valid_i)
        begin
            src = ifpa_pkg::IFPA_SRC_EXEC_STAGE;
        end
        else if (jump_valid_i)
        begin
            src = ifpa_pkg::IFPA_SRC_ADDR_STAGE;
        end
        else
        begin
            src = ifpa_pkg::IFPA_SRC_SEQ;
        end
    end
    assign redirect = (src != ifpa_pkg::IFPA_SRC_SEQ);
    assign redirect_addr = (src == ifpa_pkg::IFPA_SRC_EXEC_STAGE) ? vector_addr_i : jump_target_i;
    assign redirect_variable = (src == ifpa_pkg::IFPA_SRC_EXEC_STAGE) ? 1'b0 : jump_variable_i;

    // interlock: memory wait or core hold freezes
    assign advance = mem_ready_i && !hold_i;
    // no room for 48 bits stalls fetch
    assign fetch_go = advance && (!variable_mode || fifo_room);
    assign fetch_stall_o = variable_mode && !fifo_room;

    // ----------------------------------------
    // fetch1
    // ----------------------------------------
    // space switch on branch
    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            variable_mode <= ifpa_pkg::RESET_VARIABLE;
        end
        else if (redirect)
        begin
            variable_mode <= redirect_variable;
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            fetch_stage_address <= ifpa_pkg::RESET_ADDR;
        end
        else if (redirect)
        begin
            fetch_stage_address <= redirect_addr;
        end
        else if (fetch_go)
        begin
            fetch_stage_address <= fetch_stage_address + ifpa_step(variable_mode);
        end
    end
    assign mem_addr_o = fetch_stage_address;
    assign mem_req_o = !redirect && !hold_i && (!variable_mode || fifo_room);
    assign cache_lookup_o = mem_req_o;

    // ----------------------------------------
    // fetch2
    // ----------------------------------------
    // redirect kills younger stages
    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            f2_valid <= 1'b0;
            f2_addr <= ifpa_pkg::RESET_ADDR;
            f2_hit <= 1'b0;
        end
        else if (redirect)
        begin
            f2_valid <= 1'b0;
        end
        else if (advance)
        begin
            f2_valid <= fetch_go;
            f2_addr <= fetch_stage_address;
            f2_hit <= cache_hit_i;
        end
    end

    logic [47:0] f2_word;
    assign f2_word = f2_hit ? cache_data_i : mem_data_i;

    // ----------------------------------------
    // alignment fifo
    // ----------------------------------------
    // alignment storage
    ifpa_align_fifo #(
        .DEPTH(DEPTH),
        .WORD_W(ifpa_pkg::SHORT_W)
    ) u_align (
        .core_clk_i(core_clk_i),
        .reset_n_i(reset_n_i),
        .flush_i(redirect),
        .push_i(f2_valid && advance && variable_mode),
        .push_data_i(f2_word),
        .pop_len_i((advance && dec_ready) ? dec_len : 2'h0),
        .room_o(fifo_room),
        .count_o(fifo_count),
        .head_o(fifo_head)
    );

    // length from decoder, at least one word
    assign dec_len = variable_mode ? ((instr_len_i == 2'h0) ? 2'h1 : instr_len_i) : 2'h1;
    assign dec_ready = variable_mode ? (fifo_count >= {1'b0, dec_len}) : dec_valid;

    // ----------------------------------------
    // decode
    // ----------------------------------------
    // decode register
    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            dec_valid <= 1'b0;
            dec_word <= '0;
            dec_miss <= 1'b0;
            decode_stage_address <= ifpa_pkg::RESET_ADDR;
        end
        else if (redirect)
        begin
            dec_valid <= 1'b0;
            decode_stage_address <= redirect_addr;
        end
        else if (advance)
        begin
            dec_valid <= f2_valid && !variable_mode;
            dec_word <= f2_word;
            dec_miss <= f2_valid && !f2_hit;
            if (!variable_mode && f2_valid)
            begin
                decode_stage_address <= f2_addr;
            end
            else if (variable_mode && dec_ready)
            begin
                decode_stage_address <= decode_stage_address + 24'(dec_len);
            end
        end
    end
    assign decode_valid_o = variable_mode ? dec_ready : dec_valid;
    assign decode_instr_o = variable_mode ? fifo_head : dec_word;
    assign decode_variable_o = variable_mode;
    assign cache_fill_o = dec_valid && dec_miss;
    assign cache_fill_addr_o = decode_stage_address;
    assign cache_fill_data_o = dec_word;

    // ----------------------------------------
    // address and execute
    // ----------------------------------------
    // pc from stages
    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            addr_valid <= 1'b0;
            addr_stage <= ifpa_pkg::RESET_ADDR;
            addr_len <= 2'h1;
            exec_valid <= 1'b0;
            exec_len <= 2'h1;
            pc <= ifpa_pkg::RESET_ADDR;
        end
        else if (advance)
        begin
            addr_valid <= decode_valid_o && !redirect;
            addr_stage <= decode_stage_address;
            addr_len <= dec_len;
            exec_valid <= addr_valid && !vector_valid_i;
            exec_len <= addr_len;
            if (addr_valid && !vector_valid_i)
            begin
                pc <= addr_stage;
            end
        end
    end
    assign fetch_stage_address_o = fetch_stage_address;
    assign decode_stage_address_o = decode_stage_address;
    assign pc_o = pc;
    assign exec_valid_o = exec_valid;
    assign exec_len_o = exec_len;
    assign variable_mode_o = variable_mode;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_fixed_step;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (!redirect && fetch_go && !variable_mode) |=> fetch_stage_address == $past(fetch_stage_address) + 24'h1;
    endproperty
    a_fixed_step: assert property (p_fixed_step) else $error("fixed fetch step wrong");

    property p_var_step;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (!redirect && fetch_go && variable_mode) |=> fetch_stage_address == $past(fetch_stage_address) + 24'h3;
    endproperty
    a_var_step: assert property (p_var_step) else $error("variable fetch step wrong");

    property p_stall_full;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (!redirect && variable_mode && !fifo_room) |=> fetch_stage_address == $past(fetch_stage_address);
    endproperty
    a_stall_full: assert property (p_stall_full) else $error("fetch moved while fifo full");

    property p_flush;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        redirect |=> !f2_valid && !dec_valid && fifo_count == 3'h0;
    endproperty
    a_flush: assert property (p_flush) else $error("redirect did not flush");

    property p_vector_fixed;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        vector_valid_i |=> !variable_mode && fetch_stage_address == $past(vector_addr_i);
    endproperty
    a_vector_fixed: assert property (p_vector_fixed) else $error("vector not in fixed mode");

    property p_jump_mode;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (jump_valid_i && !vector_valid_i) |=> variable_mode == $past(jump_variable_i);
    endproperty
    a_jump_mode: assert property (p_jump_mode) else $error("space not switched");

    property p_fifo_bound;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        fifo_count <= 3'h5;
    endproperty
    a_fifo_bound: assert property (p_fifo_bound) else $error("fifo above five words");

    property p_seq_flow;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (advance && dec_valid && !variable_mode && !redirect) ##1 (advance && !redirect) |=> exec_valid;
    endproperty
    a_seq_flow: assert property (p_seq_flow) else $error("pipeline lost an instruction");
    c_redirect: cover property (@(posedge core_clk_i) disable iff (!reset_n_i) redirect);
    c_full: cover property (@(posedge core_clk_i) disable iff (!reset_n_i) fetch_stall_o);
    c_var_exec: cover property (@(posedge core_clk_i) disable iff (!reset_n_i) exec_valid && variable_mode);
endmodule : ifpa_pipeline

// >>> sim/ifpa_mem_model.sv
// instruction memory and cache model for the fetch pipeline bench
`timescale 1ns/1ps
module ifpa_mem_model (
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire logic [23:0] mem_addr_i,
    input wire logic mem_req_i,
    input wire logic hit_en_i,
    input wire logic slow_i,
    output logic mem_ready_o,
    output logic cache_hit_o,
    output logic [47:0] cache_data_o,
    output logic [47:0] mem_data_o
);
    logic [23:0] addr_q;
    logic tick;

    function automatic logic [47:0] word(input logic [23:0] a);
        word = {a[15:0], a[15:0] + 16'h0001, a[15:0] + 16'h0002};
    endfunction : word

    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            addr_q <= 24'h000000;
            tick <= 1'b0;
        end
        else
        begin
            tick <= ~tick;
            if (mem_req_i && mem_ready_o)
                addr_q <= mem_addr_i;
        end
    end

    // slow mode stretches every other cycle
    assign mem_ready_o = !slow_i || tick;
    // bus not held while not ready, so stale data cannot pass
    assign mem_data_o = mem_ready_o ? word(addr_q) : ~word(addr_q);
    assign cache_hit_o = hit_en_i && mem_req_i && mem_addr_i[2];
    // cache copy differs from memory so the source is visible
    assign cache_data_o = ~word(addr_q);
endmodule : ifpa_mem_model

// >>> sim/tb_top.sv
// self-checking bench for the instruction fetch pipeline
`timescale 1ns/1ps
module tb_top;
    logic core_clk_i, reset_n_i, jump_valid_i, jump_variable_i, vector_valid_i, hold_i;
    logic cache_hit_i, mem_ready_i, mem_req_o, cache_fill_o, decode_valid_o, exec_valid_o;
    logic variable_mode_o, fetch_stall_o, hit_en, slow, cache_lookup_o, decode_variable_o;
    logic [23:0] jump_target_i, vector_addr_i, mem_addr_o, cache_fill_addr_o;
    logic [23:0] fetch_stage_address_o, decode_stage_address_o, pc_o;
    logic [47:0] cache_data_i, mem_data_i, cache_fill_data_o, decode_instr_o;
    logic [1:0] instr_len_i, exec_len_o;
    int n_fail = 0;
    int n_checks = 0;
    int st, ne;

    ifpa_pipeline i_dut (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .jump_valid_i(jump_valid_i),
        .jump_target_i(jump_target_i), .jump_variable_i(jump_variable_i), .vector_valid_i(vector_valid_i),
        .vector_addr_i(vector_addr_i), .cache_hit_i(cache_hit_i), .cache_data_i(cache_data_i),
        .mem_data_i(mem_data_i), .mem_ready_i(mem_ready_i), .instr_len_i(instr_len_i), .hold_i(hold_i),
        .mem_addr_o(mem_addr_o), .mem_req_o(mem_req_o), .cache_lookup_o(cache_lookup_o), .cache_fill_o(cache_fill_o),
        .cache_fill_addr_o(cache_fill_addr_o), .cache_fill_data_o(cache_fill_data_o),
        .decode_instr_o(decode_instr_o), .decode_valid_o(decode_valid_o), .decode_variable_o(decode_variable_o),
        .fetch_stage_address_o(fetch_stage_address_o), .decode_stage_address_o(decode_stage_address_o),
        .pc_o(pc_o), .exec_valid_o(exec_valid_o), .exec_len_o(exec_len_o), .variable_mode_o(variable_mode_o),
        .fetch_stall_o(fetch_stall_o));

    ifpa_mem_model i_mem (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .mem_addr_i(mem_addr_o),
        .mem_req_i(mem_req_o), .hit_en_i(hit_en), .slow_i(slow), .mem_ready_o(mem_ready_i),
        .cache_hit_o(cache_hit_i), .cache_data_o(cache_data_i), .mem_data_o(mem_data_i));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [47:0] fetch_word(input logic [23:0] a);
        fetch_word = {a[15:0], a[15:0] + 16'h0001, a[15:0] + 16'h0002};
    endfunction : fetch_word

    task automatic check(input logic [47:0] got, input logic [47:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_sim

    task automatic redirect(input logic [23:0] tgt, input logic var_t);
        @(posedge core_clk_i);
        hold_i <= 1'b0;
        jump_valid_i <= 1'b1;
        jump_target_i <= tgt;
        jump_variable_i <= var_t;
        @(posedge core_clk_i);
        jump_valid_i <= 1'b0;
    endtask : redirect

    // sequence tracker: fetch, decode and execute must each walk from start
    task automatic run(input int ncyc, input logic vm, input logic [23:0] start, input logic hold_en,
        output int stalls, output int nexec);
        logic [23:0] fa, da, pa, e, step;
        logic fs, ds, ps, adv;
        fs = 0;
        ds = 0;
        ps = 0;
        stalls = 0;
        nexec = 0;
        step = (!vm || instr_len_i == 2'h0) ? 24'h000001 : {22'h0, instr_len_i};
        for (int i = 0; i < ncyc; i++)
        begin
            @(negedge core_clk_i);
            adv = mem_ready_i && !hold_i;
            check(48'(variable_mode_o), 48'(vm));
            check(48'(decode_variable_o), 48'(vm));
            if (mem_req_o && adv)
            begin
                check(48'(cache_lookup_o), 48'h1);
                check(48'(mem_addr_o), 48'(fs ? fa + (vm ? 24'h000003 : 24'h000001) : start));
                fa = mem_addr_o;
                fs = 1;
            end
            if (decode_valid_o && adv)
            begin
                e = ds ? da + step : start;
                check(48'(decode_stage_address_o), 48'(e));
                if (vm)
                    check(48'(decode_instr_o[47:32]), 48'(e[15:0]));
                else
                    check(decode_instr_o, (hit_en && e[2]) ? ~fetch_word(e) : fetch_word(e));
                da = e;
                ds = 1;
            end
            // the branch itself may still retire just after a redirect
            if (exec_valid_o && adv && ds)
            begin
                e = ps ? pa + step : start;
                check(48'(pc_o), 48'(e));
                check(48'(exec_len_o), 48'(step));
                pa = e;
                ps = 1;
                nexec++;
            end
            if (fetch_stall_o)
            begin
                stalls++;
                check(48'(mem_req_o), 48'h0);
                check(48'(cache_lookup_o), 48'h0);
            end
            @(posedge core_clk_i);
            hold_i <= hold_en && (i % 4 == 2);
        end
    endtask : run

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_var_stall;
        hit_en <= 1'b0;
        instr_len_i <= 2'h1;
        redirect(24'h000100, 1'b1);
        run(40, 1'b1, 24'h000100, 1'b0, st, ne);
        check(48'(st > 0), 48'h1);
        $display("test var_stall done");
    endtask : t_var_stall

    task automatic t_lengths;
        logic [1:0] lens [3] = '{2'h2, 2'h3, 2'h0};
        for (int k = 0; k < 3; k++)
        begin
            instr_len_i <= lens[k];
            redirect(24'h000200 + 24'(k * 64), 1'b1);
            run(36, 1'b1, 24'h000200 + 24'(k * 64), 1'b0, st, ne);
            check(48'(ne >= 15), 48'h1);
        end
        $display("test lengths done");
    endtask : t_lengths

    task automatic t_freeze;
        hit_en <= 1'b1;
        slow <= 1'b1;
        redirect(24'h001000, 1'b0);
        run(40, 1'b0, 24'h001000, 1'b1, st, ne);
        slow <= 1'b0;
        $display("test freeze done");
    endtask : t_freeze

    // vector on the edge after a jump, with a competing jump: vector wins
    task automatic t_priority;
        @(posedge core_clk_i);
        jump_valid_i <= 1'b1;
        jump_target_i <= 24'h000300;
        jump_variable_i <= 1'b1;
        @(posedge core_clk_i);
        jump_target_i <= 24'h000400;
        vector_valid_i <= 1'b1;
        vector_addr_i <= 24'h000040;
        @(posedge core_clk_i);
        jump_valid_i <= 1'b0;
        vector_valid_i <= 1'b0;
        run(30, 1'b0, 24'h000040, 1'b0, st, ne);
        $display("test priority done");
    endtask : t_priority

    // ----------------------------------------
    // clock, monitors, main
    // ----------------------------------------
    initial
    begin
        core_clk_i = 1'b0;
        forever #10 core_clk_i = ~core_clk_i;
    end

    always @(negedge core_clk_i)
    begin
        if (reset_n_i && cache_fill_o)
            check(cache_fill_data_o, fetch_word(cache_fill_addr_o));
    end

    initial
    begin
        #(20 * 5000);
        n_fail++;
        end_sim();
    end

    initial
    begin
        reset_n_i = 1'b0;
        {jump_valid_i, jump_variable_i, vector_valid_i, hold_i, slow} = 5'h00;
        hit_en = 1'b1;
        jump_target_i = 24'h000000;
        vector_addr_i = 24'h000000;
        instr_len_i = 2'h1;
        repeat (6) @(posedge core_clk_i);
        @(negedge core_clk_i);
        check(48'(variable_mode_o), 48'h0);
        check(48'(fetch_stage_address_o), 48'h0);
        @(posedge core_clk_i);
        reset_n_i <= 1'b1;
        run(24, 1'b0, 24'h000000, 1'b0, st, ne);
        check(48'(ne >= 18), 48'h1);
        $display("test reset_flow done");
        t_var_stall();
        t_lengths();
        t_freeze();
        t_priority();
        end_sim();
    end
endmodule : tb_top
